// >>> verilog/flash_ctrl_pkg.sv
// Constants, register map and carrier types of the flash program/protect controller.
// Assumes an APB master on ref_clk and a flash array on the same clock.
package flash_ctrl_pkg;

	localparam int ADDR_W  = 14;
	localparam int BLK2K_W = 11;
	localparam int PB_W    = 3;
	localparam int N_PBLK  = 8;
	localparam int BLK1K_W = 10;

	localparam logic [7:0] OFS_ADDR   = 8'h00;
	localparam logic [7:0] OFS_DATA   = 8'h04;
	localparam logic [7:0] OFS_CMD    = 8'h08;
	localparam logic [7:0] OFS_USEC   = 8'h0C;
	localparam logic [7:0] OFS_PROT   = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_RIS    = 8'h18;
	localparam logic [7:0] OFS_IM     = 8'h1C;
	localparam logic [7:0] OFS_MIS    = 8'h20;
	localparam logic [7:0] OFS_ICLR   = 8'h24;
	localparam logic [7:0] OFS_USER0  = 8'h28;
	localparam logic [7:0] OFS_USER1  = 8'h2C;
	localparam logic [7:0] OFS_NVPROT = 8'h30;

	localparam int CMD_PROG  = 0;
	localparam int CMD_ERASE = 1;
	localparam int CMD_PSAVE = 2;
	localparam int CMD_USAVE = 3;
	localparam int STAT_BUSY = 0;
	localparam int STAT_ERR  = 1;
	localparam int STAT_LOCK = 2;
	localparam int EV_DONE   = 0;
	localparam int EV_ACC    = 1;

	localparam int         CLK_MHZ   = 100;
	localparam logic [7:0] USEC_RST  = 8'(CLK_MHZ);
	localparam logic [15:0] PROG_US   = 16'h0014;
	localparam logic [15:0] ERASE_US  = 16'h07D0;
	localparam logic [15:0] COMMIT_US = 16'h0001;

	typedef enum logic [1:0] {
		prot_full_access    = 2'h0,
		prot_fetch_and_read = 2'h1,
		prot_fetch_only     = 2'h3
	} prot_t;

	typedef struct packed {
		logic              rd;
		logic              prog;
		logic              erase;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
	} arr_cmd_t;

	typedef struct packed {
		logic              valid;
		logic              fetch;
		logic [ADDR_W-1:0] addr;
	} acc_req_t;

endpackage : flash_ctrl_pkg

// >>> verilog/flash_program_protect_ctrl.sv
// Flash program/erase sequencer with per-2kB protection, timing and user registers.
// Assumes an APB master and a flash array whose arr_rdata is valid while arr_cmd.rd is high.
// How it works
// - A programmed word becomes new data ANDed with the old contents.
// - Each 2 kB block holds full, fetch-and-read or fetch-only protection.
// - Full-access blocks allow reads, fetches, erase and program.
// - Fetch-and-read blocks refuse erase and program.
// - Fetch-only blocks deny data reads; fetches pass.
// - Protection only tightens; a loosening write is ignored.
// - Reset restores the committed protection.
// - A commit command makes current protection survive resets.
// - A protection violation raises the bad access event.
// - Clocks-per-microsecond times program and erase pulses, not reads.
// - Reading clocks-per-microsecond returns the held value.
// - Two user registers, 0 and 1, read and write until a user commit locks them.
// - A user commit makes user registers survive resets.
// - A failed program verify sets an error status bit.
// - A busy bit stays high until the operation has finished.
// - Erase acts on one 1 kB block, filling it with ones.
// - Finishing an erase, program or commit raises the done event.
// - Each event has an enable; only enabled ones drive irq.
// - Raw and masked event status are both readable.
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
module flash_program_protect_ctrl
	import flash_ctrl_pkg::*;
(
	// Clock, resets, clock enable
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        porn,
	input  wire logic        ce,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Flash array
	output arr_cmd_t         arr_cmd,
	input  wire logic [31:0] arr_rdata,
	// Processor access check and interrupt
	input  acc_req_t         acc_req,
	output logic             acc_deny,
	output logic             irq
);

	typedef enum logic [4:0] {
		S_IDLE   = 5'b00001,
		S_READ   = 5'b00010,
		S_PULSE  = 5'b00100,
		S_VERIFY = 5'b01000,
		S_SPARE  = 5'b10000
	} state_t;
	state_t            st_reg;
	arr_cmd_t          arr_reg;
	logic [31:0]       prdata_reg;
	logic              pready_reg;
	logic              pslverr_reg;
	logic              deny_reg;
	logic              irq_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [31:0]       data_reg;
	logic [7:0]        usec_reg;
	logic [7:0]        pre_reg;
	logic [15:0]       us_left_reg;
	logic [3:0]        op_reg;
	logic              err_reg;
	logic [1:0]        ris_reg;
	logic [1:0]        ris_next;
	logic [1:0]        im_reg;
	logic [31:0]       user_reg [2];
	logic [31:0]       user_nv_reg [2];
	logic              ulock_reg;
	prot_t             prot_reg [N_PBLK];
	prot_t             prot_nv_reg [N_PBLK];
	logic [2*N_PBLK-1:0] prot_vec;
	logic [2*N_PBLK-1:0] prot_nv_vec;
	logic [3:0]  op_sel;
	logic        acc_ph;
	logic        wr;
	logic        cmd_wr;
	logic        blk_ok;
	logic        refused;
	logic        tick;
	logic        pulse_done;
	logic        op_end;
	logic        deny_now;
	logic        hit;
	logic [31:0] rd_mux;
	assign prdata   = prdata_reg;
	assign pready   = pready_reg;
	assign pslverr  = pslverr_reg;
	assign arr_cmd  = arr_reg;
	assign acc_deny = deny_reg;
	assign irq      = irq_reg;
	assign acc_ph  = psel & penable;
	assign op_sel  = st_reg == S_IDLE ? pwdata[3:0] : op_reg;
	assign wr      = acc_ph & pready_reg & pwrite;
	assign cmd_wr  = wr && paddr == OFS_CMD && st_reg == S_IDLE;
	assign blk_ok  = prot_reg[addr_reg[BLK2K_W +: PB_W]] == prot_full_access;
	assign refused = cmd_wr && (pwdata[CMD_PROG] || pwdata[CMD_ERASE]) && !blk_ok;
	assign tick    = {1'b0, pre_reg} + 9'h001 >= {1'b0, usec_reg};
	assign pulse_done = st_reg == S_PULSE && tick && us_left_reg <= 16'h0001;
	assign op_end  = (pulse_done && !op_reg[CMD_PROG]) || st_reg == S_VERIFY;
	assign deny_now = acc_req.valid && !acc_req.fetch &&
		prot_reg[acc_req.addr[BLK2K_W +: PB_W]] == prot_fetch_only;
	// Register read decode
	always_comb begin
		hit    = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			OFS_ADDR:   rd_mux = 32'(addr_reg);
			OFS_DATA:   rd_mux = data_reg;
			OFS_CMD:    rd_mux = 32'(op_reg);
			OFS_USEC:   rd_mux = 32'(usec_reg);
			OFS_PROT:   rd_mux = 32'(prot_vec);
			OFS_NVPROT: rd_mux = 32'(prot_nv_vec);
			OFS_STATUS: rd_mux = 32'({ulock_reg, err_reg, st_reg != S_IDLE});
			OFS_RIS:    rd_mux = 32'(ris_reg);
			OFS_IM:     rd_mux = 32'(im_reg);
			OFS_MIS:    rd_mux = 32'(ris_reg & im_reg);
			OFS_ICLR:   rd_mux = 32'h0000_0000;
			OFS_USER0:  rd_mux = user_reg[0];
			OFS_USER1:  rd_mux = user_reg[1];
			default:    hit = 1'b0;
		endcase
	end
	// APB answer: one wait state, data and error loaded with pready
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (ce) begin
			pready_reg <= acc_ph & !pready_reg;
			if (acc_ph && !pready_reg) begin
				prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr_reg <= !hit;
			end
		end
	end
	// Plain software registers
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			addr_reg <= '0;
			data_reg <= 32'h0000_0000;
			usec_reg <= USEC_RST;
			im_reg   <= 2'h0;
		end else if (ce && wr) begin
			if (paddr == OFS_ADDR)
				addr_reg <= pwdata[ADDR_W-1:0];
			if (paddr == OFS_DATA)
				data_reg <= pwdata;
			if (paddr == OFS_USEC)
				usec_reg <= pwdata[7:0];
			if (paddr == OFS_IM)
				im_reg <= pwdata[1:0];
		end
	end
	// Protection: live copy per block restored from the committed copy at reset
	for (genvar i = 0; i < N_PBLK; i++) begin : g_prot
		prot_t nw;
		assign nw = prot_t'(pwdata[2*i +: 2]);
		assign prot_vec[2*i +: 2]    = prot_reg[i];
		assign prot_nv_vec[2*i +: 2] = prot_nv_reg[i];
		always_ff @(posedge ref_clk) begin
			if (!resetn)
				prot_reg[i] <= prot_nv_reg[i];
			else if (ce && wr && paddr == OFS_PROT && pwdata[2*i +: 2] != 2'h2 &&
				nw >= prot_reg[i])
				prot_reg[i] <= nw;
		end
		always_ff @(posedge ref_clk) begin
			if (!porn)
				prot_nv_reg[i] <= prot_full_access;
			else if (ce && pulse_done && op_reg[CMD_PSAVE])
				prot_nv_reg[i] <= prot_reg[i];
		end
	end
	// User registers, live and committed
	for (genvar u = 0; u < 2; u++) begin : g_user
		always_ff @(posedge ref_clk) begin
			if (!resetn)
				user_reg[u] <= user_nv_reg[u];
			else if (ce && wr && !ulock_reg && paddr == (u == 0 ? OFS_USER0 : OFS_USER1))
				user_reg[u] <= pwdata;
		end
		always_ff @(posedge ref_clk) begin
			if (!porn)
				user_nv_reg[u] <= 32'hFFFF_FFFF;
			else if (ce && pulse_done && op_reg[CMD_USAVE])
				user_nv_reg[u] <= user_reg[u];
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!porn)
			ulock_reg <= 1'b0;
		else if (ce && pulse_done && op_reg[CMD_USAVE])
			ulock_reg <= 1'b1;
	end
	// Microsecond timer for program, erase and commit pulses
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pre_reg     <= 8'h00;
			us_left_reg <= 16'h0000;
		end else if (ce) begin
			if (st_reg != S_PULSE) begin
				pre_reg     <= 8'h00;
				us_left_reg <= op_sel[CMD_PROG] ? PROG_US :
					(op_sel[CMD_ERASE] ? ERASE_US : COMMIT_US);
			end else if (tick) begin
				pre_reg     <= 8'h00;
				us_left_reg <= us_left_reg - 16'h0001;
			end else begin
				pre_reg <= pre_reg + 8'h01;
			end
		end
	end
	// Operation sequencer
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			st_reg  <= S_IDLE;
			arr_reg <= '0;
			op_reg  <= 4'h0;
			err_reg <= 1'b0;
		end else if (ce) begin
			unique case (st_reg)
				S_IDLE: begin
					if (cmd_wr && !refused) begin
						op_reg       <= 4'h0;
						arr_reg.addr <= addr_reg;
						if (pwdata[CMD_PROG]) begin
							op_reg[CMD_PROG] <= 1'b1;
							err_reg          <= 1'b0;
							arr_reg.rd       <= 1'b1;
							st_reg           <= S_READ;
						end else if (pwdata[CMD_ERASE]) begin
							op_reg[CMD_ERASE] <= 1'b1;
							arr_reg.addr      <= {addr_reg[ADDR_W-1:BLK1K_W],
								BLK1K_W'(0)};
							arr_reg.erase     <= 1'b1;
							st_reg            <= S_PULSE;
						end else if (pwdata[CMD_PSAVE]) begin
							op_reg[CMD_PSAVE] <= 1'b1;
							st_reg            <= S_PULSE;
						end else if (pwdata[CMD_USAVE]) begin
							op_reg[CMD_USAVE] <= 1'b1;
							st_reg            <= S_PULSE;
						end
					end else if (refused) begin
						err_reg <= 1'b1;
					end
				end
				S_READ: begin
					arr_reg.rd    <= 1'b0;
					arr_reg.wdata <= data_reg & arr_rdata;
					arr_reg.prog  <= 1'b1;
					st_reg        <= S_PULSE;
				end
				S_PULSE: begin
					if (pulse_done) begin
						arr_reg.prog  <= 1'b0;
						arr_reg.erase <= 1'b0;
						arr_reg.rd    <= op_reg[CMD_PROG];
						st_reg        <= op_reg[CMD_PROG] ? S_VERIFY : S_IDLE;
					end
				end
				S_VERIFY: begin
					arr_reg.rd <= 1'b0;
					err_reg    <= arr_rdata != arr_reg.wdata;
					st_reg     <= S_IDLE;
				end
				default: st_reg <= S_IDLE;
			endcase
		end
	end
	// Events, access denial and interrupt; a set in the clear cycle wins
	always_comb begin
		ris_next = ris_reg;
		if (wr && paddr == OFS_ICLR)
			ris_next = ris_next & ~pwdata[1:0];
		if (op_end)
			ris_next[EV_DONE] = 1'b1;
		if (refused || deny_now)
			ris_next[EV_ACC] = 1'b1;
	end
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ris_reg  <= 2'h0;
			deny_reg <= 1'b0;
			irq_reg  <= 1'b0;
		end else if (ce) begin
			ris_reg  <= ris_next;
			deny_reg <= deny_now;
			irq_reg  <= |(ris_next & (wr && paddr == OFS_IM ? pwdata[1:0] : im_reg));
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence s_cmd(int b);
		ce && cmd_wr && pwdata[b];
	endsequence

	a_and_merge: assert property (ce && st_reg == S_READ |=> (arr_cmd.wdata & ~$past(arr_rdata)) == 0)
		else $error("programmed word not an AND of old data");
	a_prot_tighten: assert property (ce && $past(resetn) && prot_reg[0] != $past(prot_reg[0])
		|-> prot_reg[0] > $past(prot_reg[0]))
		else $error("protection loosened");
	a_refuse_locked: assert property (ce && refused |=> st_reg == S_IDLE && !arr_cmd.prog
		&& !arr_cmd.erase && ris_reg[EV_ACC])
		else $error("refused command started or not flagged");
	a_data_deny: assert property (ce && deny_now |=> acc_deny ##0 ris_reg[EV_ACC])
		else $error("fetch-only data read not denied");
	a_fetch_pass: assert property (ce && acc_req.valid && acc_req.fetch |=> !acc_deny)
		else $error("instruction fetch denied");
	a_usec_read: assert property (ce && acc_ph && !pready_reg && !pwrite && paddr == OFS_USEC
		|=> prdata[7:0] == $past(usec_reg))
		else $error("clocks per microsecond readback wrong");
	a_prog_seq: assert property (s_cmd(CMD_PROG) ##0 !refused ##1 ce |=> arr_cmd.prog)
		else $error("program pulse not started");
	a_done_busy: assert property (ce && st_reg == S_VERIFY |=> st_reg == S_IDLE
		&& ris_reg[EV_DONE])
		else $error("done event missing after program");
	a_irq_mask: assert property (irq == |(ris_reg & im_reg))
		else $error("irq disagrees with masked status");
	a_clear_evt: assert property (ce && wr && paddr == OFS_ICLR && pwdata[EV_DONE] && !op_end
		|=> !ris_reg[EV_DONE])
		else $error("done event not cleared");

endmodule : flash_program_protect_ctrl

// >>> dv/flash_array_model.sv
// Behavioural flash array of 16 kB: programming only clears bits, erase fills a 1 kB block.
// Assumes arr_cmd from the controller on ref_clk; arr_rdata is combinational.
`timescale 1ns/1ps
module flash_array_model
	import flash_ctrl_pkg::*;
(
	// Clock and fault switch
	input  wire logic        ref_clk,
	input  wire logic        stuck,
	// Array port
	input  arr_cmd_t         arr_cmd,
	output logic      [31:0] arr_rdata
);
	logic [31:0] mem [4096];

	initial foreach (mem[i]) mem[i] = 32'hFFFF_FFFF;

	// Outside a read the data lines show inverted contents, not a stable copy
	assign arr_rdata = arr_cmd.rd ? mem[arr_cmd.addr[13:2]] : ~mem[arr_cmd.addr[13:2]];

	always @(posedge ref_clk) begin
		// Stuck switch keeps bit 0 from clearing, so verify fails
		if (arr_cmd.prog)
			mem[arr_cmd.addr[13:2]] <= mem[arr_cmd.addr[13:2]] & (arr_cmd.wdata | 32'(stuck));
		if (arr_cmd.erase)
			for (int i = 0; i < 256; i++)
				mem[{arr_cmd.addr[13:10], i[7:0]}] <= 32'hFFFF_FFFF;
	end
endmodule : flash_array_model

// >>> dv/tb_flash_program_protect_ctrl.sv
// Self-checking bench of the flash controller, random data from a fixed-seed xorshift.
// Assumes the array model and the package register map.
`timescale 1ns/1ps
module tb_flash_program_protect_ctrl
	import flash_ctrl_pkg::*;
;
	logic        ref_clk, resetn, porn, psel, penable, pwrite, pready, pslverr;
	logic        acc_deny, irq, stuck, rd_err, ce;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, arr_rdata, rd_data, seed, d, e;
	arr_cmd_t    arr_cmd;
	acc_req_t    acc_req;
	int          err_count, cmp_count, prog_base;
	int          cyc = 0, prog_len = 0;

	flash_program_protect_ctrl uut (.ref_clk(ref_clk), .resetn(resetn), .porn(porn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.arr_cmd(arr_cmd), .arr_rdata(arr_rdata), .acc_req(acc_req),
		.acc_deny(acc_deny), .irq(irq));
	flash_array_model arr (.ref_clk(ref_clk), .stuck(stuck), .arr_cmd(arr_cmd),
		.arr_rdata(arr_rdata));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (arr_cmd.prog)
			prog_len <= prog_len + 1;
		if (cyc == 20000) begin
			err_count++;
			end_of_test();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		cmp_count++;
		if (got !== ex) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd_data = prdata;
		rd_err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, ex, rd_data);
	endtask : rdc

	task automatic op(input logic [31:0] a, input logic [31:0] c);
		wr(OFS_ADDR, a);
		wr(OFS_CMD, c);
		do apb(1'b0, OFS_STATUS, 32'h0); while (rd_data[STAT_BUSY] !== 1'b0);
	endtask : op

	task automatic acc(input logic f, input logic [13:0] a, input logic ex);
		acc_req <= '{1'b1, f, a};
		@(posedge ref_clk);
		acc_req <= '0;
		@(posedge ref_clk);
		chk("acc_deny", 32'(ex), 32'(acc_deny));
	endtask : acc

	task automatic rst();
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
	endtask : rst

	task automatic end_of_test();
		$display("compares %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	initial begin
		{psel, penable, pwrite, stuck, resetn, porn} = '0;
		paddr = '0;
		pwdata = '0;
		acc_req = '0;
		ce = 1'b1;
		{seed, err_count, cmp_count} = {32'h3F, 32'h0, 32'h0};
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		porn <= 1'b1;
		@(posedge ref_clk);
		rdc(OFS_USEC, 32'(USEC_RST), "usec_rst");
		rdc(8'h34, 32'h0, "unmapped");
		chk("slverr", 32'h1, 32'(rd_err));
		wr(OFS_USEC, 32'h2);
		rdc(OFS_USEC, 32'h2, "usec");
		e = rnd() & 32'hFFFF_FFFE;
		wr(OFS_DATA, e);
		wr(OFS_ADDR, 32'h100);
		prog_base = prog_len;
		wr(OFS_CMD, 32'h1 << CMD_PROG);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("busy", 32'h1, 32'(rd_data[STAT_BUSY]));
		// Ten frozen cycles stretch the running pulse by ten
		ce <= 1'b0;
		repeat (10) @(posedge ref_clk);
		ce <= 1'b1;
		op(32'h100, 32'h0);
		chk("prog_len", 32'(PROG_US) * 32'h2 + 32'hA, prog_len - prog_base);
		chk("word", e, arr.mem[64]);
		wr(OFS_USEC, 32'h1);
		for (int i = 0; i < 4; i++) begin
			d = rnd();
			e &= d;
			wr(OFS_DATA, d);
			op(32'h100, 32'h1 << CMD_PROG);
			chk("and_word", e, arr.mem[64]);
		end
		rdc(OFS_STATUS, 32'h0, "status_ok");
		rdc(OFS_RIS, 32'h1, "ris_done");
		rdc(OFS_MIS, 32'h0, "mis_off");
		chk("irq_off", 32'h0, 32'(irq));
		wr(OFS_IM, 32'h1);
		rdc(OFS_MIS, 32'h1, "mis_on");
		chk("irq_on", 32'h1, 32'(irq));
		wr(OFS_ICLR, 32'h1);
		rdc(OFS_RIS, 32'h0, "ris_clr");
		chk("irq_clr", 32'h0, 32'(irq));
		wr(OFS_DATA, 32'h0);
		op(32'h404, 32'h1 << CMD_PROG);
		op(32'h7FC, 32'h1 << CMD_ERASE);
		chk("erased", 32'hFFFF_FFFF, arr.mem[257]);
		chk("kept", e, arr.mem[64]);
		wr(OFS_PROT, 32'hD);
		wr(OFS_PROT, 32'h14);
		rdc(OFS_PROT, 32'h1D, "prot_tight");
		op(32'h0, 32'h1 << CMD_PROG);
		chk("ro_word", 32'hFFFF_FFFF, arr.mem[0]);
		chk("ro_err", 32'h1, 32'(rd_data[STAT_ERR]));
		rdc(OFS_RIS, 32'h3, "ris_ro");
		wr(OFS_ICLR, 32'h2);
		op(32'h800, 32'h1 << CMD_ERASE);
		chk("xo_err", 32'h1, 32'(rd_data[STAT_ERR]));
		rdc(OFS_RIS, 32'h3, "ris_xo");
		wr(OFS_ICLR, 32'h3);
		acc(1'b0, 14'h0900, 1'b1);
		rdc(OFS_RIS, 32'h2, "ris_bad");
		acc(1'b1, 14'h0900, 1'b0);
		acc(1'b0, 14'h0100, 1'b0);
		acc(1'b0, 14'h2100, 1'b0);
		rst();
		rdc(OFS_PROT, 32'h0, "prot_rst");
		wr(OFS_PROT, 32'h1);
		op(32'h0, 32'h1 << CMD_PSAVE);
		rdc(OFS_NVPROT, 32'h1, "nvprot");
		wr(OFS_PROT, 32'hC);
		rst();
		rdc(OFS_PROT, 32'h1, "prot_saved");
		d = rnd();
		wr(OFS_USER0, d);
		wr(OFS_USER1, ~d);
		rdc(OFS_USER0, d, "user0");
		rdc(OFS_USER1, ~d, "user1");
		op(32'h0, 32'h1 << CMD_USAVE);
		wr(OFS_USER0, 32'h0);
		rdc(OFS_USER0, d, "user0_locked");
		rst();
		rdc(OFS_USER0, d, "user0_kept");
		rdc(OFS_USER1, ~d, "user1_kept");
		wr(OFS_DATA, 32'h0);
		stuck <= 1'b1;
		op(32'h900, 32'h1 << CMD_PROG);
		chk("prog_fail", 32'h1, 32'(rd_data[STAT_ERR]));
		chk("locked", 32'h1, 32'(rd_data[STAT_LOCK]));
		end_of_test();
	end
endmodule : tb_flash_program_protect_ctrl
